/* File: include/tfl_defines.vh */
// Purpose: constants for the thermal alarm and fan loop
// Assumes: included by bare name, definitions only
// Notes: offsets are 8-bit register indices
`ifndef TFL_DEFINES_VH
`define TFL_DEFINES_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define TFL_A_CFG1 8'h00
`define TFL_A_CFG2 8'h01
`define TFL_A_STAT1 8'h02
`define TFL_A_STAT2 8'h03
`define TFL_A_LOC_HI 8'h0b
`define TFL_A_LOC_LO 8'h0c
`define TFL_A_LOC_OT 8'h0d
`define TFL_A_REM_HI 8'h0e
`define TFL_A_REM_LO 8'h0f
`define TFL_A_REM_OT 8'h10
`define TFL_A_FANCHR 8'h20
`define TFL_A_FANSPD 8'h22
`define TFL_A_LOC_LOOP 8'h24
`define TFL_A_REM_LOOP 8'h25
`define TFL_A_OTBEH 8'h3f

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define TFL_R_CFG1 8'h80
`define TFL_R_CFG2 8'h03
`define TFL_R_HI 8'h46
`define TFL_R_LO 8'h00
`define TFL_R_OT 8'h55
`define TFL_R_FANCHR 8'h05
`define TFL_R_FANSPD 8'h05
`define TFL_R_LOOP 8'h52
`define TFL_R_OTBEH 8'h80

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define TFL_B_AUTO 7
`define TFL_B_SEL_HI 6
`define TFL_B_SEL_LO 5
`define TFL_B_FILT 4
`define TFL_B_RPM 3
`define TFL_B_EN_LOC 0
`define TFL_B_EN_REM 1
`define TFL_B_OT2FAN 7
`define TFL_S1_ALARM 0
`define TFL_S1_FFAULT 1
`define TFL_S1_RHI 2
`define TFL_S1_RLO 3
`define TFL_S1_ROT 4
`define TFL_S1_DIODE 5
`define TFL_S1_LHI 6
`define TFL_S1_LLO 7
`define TFL_S2_LOT 6
`define TFL_S2_EXT 7

// ------------------------------------------------------------
// fan loop values
// ------------------------------------------------------------
`define TFL_DUTY_FULL 4'hf
`define TFL_HYST_C 8'h05
`define TFL_TMIN_STEP_SH 2
`define TFL_RANGE_MAX 3'h4
`define TFL_REVISION 7'h01
`define TFL_MODE_AUTO 2'h0
`define TFL_MODE_FILT 2'h1
`define TFL_MODE_DIRECT 2'h2
`define TFL_MODE_RPM 2'h3
`define TFL_ADDR_LOW 2'h0
`define TFL_ADDR_OPEN 2'h1
`define TFL_ADDR_HIGH 2'h2

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define TFL_CLK_MHZ 125
`define TFL_TIME_UNIT_MS 1
`define TFL_SPIN_MS_0 200
`define TFL_SPIN_MS_1 400
`define TFL_SPIN_MS_2 600
`define TFL_SPIN_MS_3 800
`define TFL_SPIN_MS_4 1000
`define TFL_SPIN_MS_5 2000
`define TFL_SPIN_MS_6 4000
`define TFL_SPIN_MS_7 8000
`define TFL_PIN_DELAY 3

`endif

/* File: logic/tfl_chan.v */
// Purpose: limit checks and fan duty for one temperature channel
// Assumes: temperatures are signed whole degrees, conv is a pulse
// Notes: results update only on conv, except ot_new, which clears the next cycle
`timescale 1ns/1ns
`include "tfl_defines.vh"
module tfl_chan (
  // clock and reset
  input wire sys_clk,
  input wire reset,
  // reading
  input wire conv,
  input wire [7:0] temp,
  // limits
  input wire [7:0] lim_hi,
  input wire [7:0] lim_lo,
  input wire [7:0] lim_ot,
  // loop settings
  input wire [7:0] loop_cfg,
  input wire [3:0] min_duty,
  // results
  output reg hi_viol,
  output reg lo_viol,
  output reg ot_active,
  output reg ot_new,
  output reg fan_on,
  output reg [3:0] duty
);

  wire signed [8:0] t_s = {temp[7], temp};
  wire signed [8:0] ot_s = {lim_ot[7], lim_ot};
  wire signed [8:0] hyst_s = {1'b0, `TFL_HYST_C};
  // fan-on temperature is held as a multiple of four degrees
  wire [7:0] tmin_c = {1'b0, loop_cfg[7:3], 2'b00};
  wire signed [8:0] tmin_s = {1'b0, tmin_c};
  wire signed [8:0] diff = t_s - tmin_s;
  wire [2:0] rng = (loop_cfg[2:0] > `TFL_RANGE_MAX) ?
    `TFL_RANGE_MAX : loop_cfg[2:0];
  // steps of one duty code are 2^range/2 degrees: 2*diff >> range
  wire [9:0] steps = {diff[8:0], 1'b0} >> rng;
  wire [10:0] sum = {7'h00, min_duty} + {1'b0, steps};
  reg [3:0] duty_next;
  reg on_next;

  always @* begin
    on_next = fan_on;
    // (RULE_16) on above fan-on temperature
    if (diff > 9'sd0)
      on_next = 1'b1;
    // (RULE_18) off five below fan-on temperature
    else if (diff < -hyst_s)
      on_next = 1'b0;
    duty_next = 4'h0;
    // (RULE_17) slope from span, full at top
    if (on_next) begin
      if (diff <= 9'sd0)
        duty_next = min_duty;
      else if (sum > {7'h00, `TFL_DUTY_FULL})
        duty_next = `TFL_DUTY_FULL;
      else
        duty_next = sum[3:0];
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      hi_viol <= 1'b0;
      lo_viol <= 1'b0;
      ot_active <= 1'b0;
      ot_new <= 1'b0;
      fan_on <= 1'b0;
      duty <= 4'h0;
    end else begin
      ot_new <= 1'b0;
      // (RULE_22) evaluate once per conversion
      if (conv) begin
        hi_viol <= $signed(temp) > $signed(lim_hi);
        lo_viol <= $signed(temp) < $signed(lim_lo);
        fan_on <= on_next;
        duty <= duty_next;
        // (RULE_13) hold until five below limit
        if (t_s > ot_s) begin
          ot_active <= 1'b1;
          ot_new <= ~ot_active;
        end else if (t_s < ot_s - hyst_s) begin
          ot_active <= 1'b0;
        end
      end
    end
  end

endmodule // tfl_chan

/* File: logic/tfl_sync2.v */
// Purpose: two flip-flop synchroniser for one pin level
// Assumes: input is asynchronous to sys_clk
// Notes: first stage feeds only the second
`timescale 1ns/1ns
module tfl_sync2 #(
  parameter RESET_VAL = 1'b0
) (
  // clock and reset
  input wire sys_clk,
  input wire reset,
  // level in and out
  input wire async_in,
  output reg sync_out
);

  reg meta_reg;

  always @(posedge sys_clk) begin
    if (reset) begin
      meta_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // tfl_sync2

/* File: logic/tfl_top.v */
// Purpose: thermal alarms, status flags and automatic fan duty
// Assumes: register port and readings come from sys_clk logic
// Notes: pins pass a two flip-flop synchroniser first
`timescale 1ns/1ns
`include "tfl_defines.vh"

// Summary of operation
// (RULE_01) address pin sampled once after reset sets two address bits
// (RULE_02) alert low on enabled low or high limit violation
// (RULE_03) overtemp pin driven low above overtemp limit, never masked
// (RULE_04) own overtemp forces full fan only when enable bit set
// (RULE_05) external pull low sets status 2 bit 7, forces full fan
// (RULE_06) clearing channel enable clears and masks its events
// (RULE_07) alarm-speed and fan-fault clear on read; alarm needs re-entry
// (RULE_08) fan-fault sets on every tach failure
// (RULE_09) high and low status bits clear on read, re-set on next conversion result
// (RULE_10) remote overtemp status bit sets, clears on status 1 read
// (RULE_11) diode error caught at power-up, cannot be cleared
// (RULE_12) local overtemp and external bits clear on status 2 read
// (RULE_13) overtemp asserts both outputs; pin holds until five below
// (RULE_14) overtemp alert re-arms only below limit minus five
// (RULE_15) four fan modes: auto, filtered, direct duty, speed feedback; filtered runs the plain loop, speed feedback uses the direct duty field
// (RULE_16) auto fan starts above fan-on temperature after spin-up
// (RULE_17) duty rises with span, full at fan-on plus span
// (RULE_18) fan stays on until five below fan-on temperature
// (RULE_19) fan-on temperature set in four degree steps, shifts curve
// (RULE_20) alert released after alert response, reasserted on next conversion result
// (RULE_21) duty at fan-on from four-bit minimum duty field
// (RULE_22) limits and duty evaluated once per conversion result
module tfl_top #(
  parameter MS_CYCLES = `TFL_CLK_MHZ * 1000 * `TFL_TIME_UNIT_MS
) (
  // clock and reset
  input wire sys_clk,
  input wire reset,
  // register port from the bus engine
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire ara_ack,
  // readings
  input wire conv_done,
  input wire [7:0] local_temp,
  input wire [7:0] remote_temp,
  input wire tach_fail,
  input wire diode_err,
  // pins
  input wire addr_pin_high,
  input wire addr_pin_low,
  input wire overtemp_pin_n_i,
  output wire overtemp_pin_n_o,
  output wire overtemp_pin_n_oe_n,
  output wire alert_n,
  // fan and bus address
  output reg [3:0] pwm_duty,
  output reg [1:0] fan_mode,
  output reg [1:0] bus_addr_low
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg [7:0] cfg1_reg, cfg2_reg, fanchr_reg, fanspd_reg, otbeh_reg;
  reg [7:0] loc_hi_reg, loc_lo_reg, loc_ot_reg;
  reg [7:0] rem_hi_reg, rem_lo_reg, rem_ot_reg;
  reg [7:0] loc_loop_reg, rem_loop_reg;
  reg [7:0] stat1_reg, stat2_reg;
  reg alert_reg, strap_done_reg, alarm_prev_reg;
  reg [1:0] strap_wait_reg;
  reg [`TFL_PIN_DELAY-1:0] drive_hist_reg;
  reg [31:0] spin_cnt_reg;
  reg spin_reg;

  wire addr_hi_s, addr_lo_s, ot_in_s;
  wire l_hi, l_lo, l_ot, l_new, l_on;
  wire r_hi, r_lo, r_ot, r_new, r_on;
  wire [3:0] l_duty, r_duty;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  tfl_sync2 #(.RESET_VAL(1'b0)) u_sync_ahi (
    .sys_clk(sys_clk), .reset(reset),
    .async_in(addr_pin_high), .sync_out(addr_hi_s));
  tfl_sync2 #(.RESET_VAL(1'b0)) u_sync_alo (
    .sys_clk(sys_clk), .reset(reset),
    .async_in(addr_pin_low), .sync_out(addr_lo_s));
  tfl_sync2 #(.RESET_VAL(1'b1)) u_sync_ot (
    .sys_clk(sys_clk), .reset(reset),
    .async_in(overtemp_pin_n_i), .sync_out(ot_in_s));

  // ------------------------------------------------------------
  // channels
  // ------------------------------------------------------------
  // (RULE_19) fan-on field is in four degree units
  tfl_chan u_loc (
    .sys_clk(sys_clk), .reset(reset), .conv(conv_done),
    .temp(local_temp), .lim_hi(loc_hi_reg), .lim_lo(loc_lo_reg),
    .lim_ot(loc_ot_reg), .loop_cfg(loc_loop_reg),
    .min_duty(fanspd_reg[3:0]), .hi_viol(l_hi), .lo_viol(l_lo),
    .ot_active(l_ot), .ot_new(l_new), .fan_on(l_on), .duty(l_duty));
  tfl_chan u_rem (
    .sys_clk(sys_clk), .reset(reset), .conv(conv_done),
    .temp(remote_temp), .lim_hi(rem_hi_reg), .lim_lo(rem_lo_reg),
    .lim_ot(rem_ot_reg), .loop_cfg(rem_loop_reg),
    .min_duty(fanspd_reg[3:0]), .hi_viol(r_hi), .lo_viol(r_lo),
    .ot_active(r_ot), .ot_new(r_new), .fan_on(r_on), .duty(r_duty));

  // one cycle after conv_done the channel results are fresh
  reg eval_reg;
  always @(posedge sys_clk) begin
    if (reset)
      eval_reg <= 1'b0;
    else
      eval_reg <= conv_done;
  end

  // ------------------------------------------------------------
  // overtemp pin
  // ------------------------------------------------------------
  wire en_loc = cfg2_reg[`TFL_B_EN_LOC];
  wire en_rem = cfg2_reg[`TFL_B_EN_REM];
  // (RULE_03) unmasked: enables do not gate the pin
  wire ot_drive = l_ot | r_ot;
  assign overtemp_pin_n_o = 1'b0;
  assign overtemp_pin_n_oe_n = ~ot_drive;

  // own drive takes a few cycles to leave the synchroniser
  always @(posedge sys_clk) begin
    if (reset)
      drive_hist_reg <= {`TFL_PIN_DELAY{1'b0}};
    else
      drive_hist_reg <= {drive_hist_reg[`TFL_PIN_DELAY-2:0], ot_drive};
  end
  wire own_recent = ot_drive | (|drive_hist_reg);
  // (RULE_05) low pin while we are not driving it
  wire ext_pull = ~ot_in_s & ~own_recent;

  // (RULE_04) own overtemp forces fan only when enabled
  wire force_full = (ot_drive & otbeh_reg[`TFL_B_OT2FAN]) | ext_pull;

  // ------------------------------------------------------------
  // strap capture
  // ------------------------------------------------------------
  // (RULE_01) sample address strap once after reset
  always @(posedge sys_clk) begin
    if (reset) begin
      strap_wait_reg <= 2'h0;
      strap_done_reg <= 1'b0;
      bus_addr_low <= `TFL_ADDR_OPEN;
    end else if (!strap_done_reg) begin
      strap_wait_reg <= {strap_wait_reg[0], 1'b1};
      strap_done_reg <= strap_wait_reg[1];
      if (addr_hi_s)
        bus_addr_low <= `TFL_ADDR_HIGH;
      else if (addr_lo_s)
        bus_addr_low <= `TFL_ADDR_LOW;
      else
        bus_addr_low <= `TFL_ADDR_OPEN;
    end
  end

  // ------------------------------------------------------------
  // status flags
  // ------------------------------------------------------------
  wire rd1 = reg_rd & (reg_addr == `TFL_A_STAT1);
  wire rd2 = reg_rd & (reg_addr == `TFL_A_STAT2);
  wire alarm_enter = force_full & ~alarm_prev_reg;
  reg [7:0] set1, set2, stat1_next, stat2_next;

  always @* begin
    set1 = 8'h00;
    set2 = 8'h00;
    // (RULE_07) alarm speed only on entering it
    set1[`TFL_S1_ALARM] = alarm_enter;
    // (RULE_08) every tach failure
    set1[`TFL_S1_FFAULT] = tach_fail;
    // (RULE_09) re-set on each conversion result while violated
    set1[`TFL_S1_RHI] = eval_reg & r_hi & en_rem;
    set1[`TFL_S1_RLO] = eval_reg & r_lo & en_rem;
    set1[`TFL_S1_LHI] = eval_reg & l_hi & en_loc;
    set1[`TFL_S1_LLO] = eval_reg & l_lo & en_loc;
    // (RULE_10) remote overtemp
    set1[`TFL_S1_ROT] = eval_reg & r_new & en_rem;
    // (RULE_12) local overtemp and external pull
    set2[`TFL_S2_LOT] = eval_reg & l_new & en_loc;
    set2[`TFL_S2_EXT] = ext_pull;
    // set wins over read clear
    stat1_next = (rd1 ? 8'h00 : stat1_reg) | set1;
    stat2_next = (rd2 ? 8'h00 : stat2_reg) | set2;
    // (RULE_11) diode error is sticky against reads
    stat1_next[`TFL_S1_DIODE] = stat1_reg[`TFL_S1_DIODE] |
      (~strap_done_reg & diode_err);
    // (RULE_06) disabled channel flags are held clear
    if (!en_rem) begin
      stat1_next[`TFL_S1_RHI] = 1'b0;
      stat1_next[`TFL_S1_RLO] = 1'b0;
      stat1_next[`TFL_S1_ROT] = 1'b0;
    end
    if (!en_loc) begin
      stat1_next[`TFL_S1_LHI] = 1'b0;
      stat1_next[`TFL_S1_LLO] = 1'b0;
      stat2_next[`TFL_S2_LOT] = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // alert output
  // ------------------------------------------------------------
  // overtemp sources raise the alert only on a new event
  wire alert_cause = eval_reg & ((en_loc & (l_hi | l_lo | l_new)) |
    (en_rem & (r_hi | r_lo | r_new)));
  wire en_fall = (cfg2_reg[`TFL_B_EN_LOC] & ~reg_wdata[`TFL_B_EN_LOC]) |
    (cfg2_reg[`TFL_B_EN_REM] & ~reg_wdata[`TFL_B_EN_REM]);
  wire cfg2_wr = reg_wr & (reg_addr == `TFL_A_CFG2);

  always @(posedge sys_clk) begin
    if (reset) begin
      alert_reg <= 1'b0;
    // (RULE_02) (RULE_14) enabled violation or new overtemp event
    end else if (alert_cause) begin
      alert_reg <= 1'b1;
    // (RULE_13) (RULE_20) status read or alert response releases
    end else if (rd1 | rd2 | ara_ack | (cfg2_wr & en_fall)) begin
      alert_reg <= 1'b0;
    end
  end
  assign alert_n = ~alert_reg;

  // ------------------------------------------------------------
  // fan duty
  // ------------------------------------------------------------
  wire auto_on = cfg1_reg[`TFL_B_AUTO];
  wire both_ch = cfg1_reg[`TFL_B_SEL_HI] & cfg1_reg[`TFL_B_SEL_LO];
  wire loop_on = both_ch ? (l_on | r_on) : r_on;
  wire [3:0] loop_duty = (both_ch && l_duty > r_duty) ? l_duty : r_duty;
  reg [31:0] spin_ms;

  always @* begin
    case (fanchr_reg[2:0])
      3'h0: spin_ms = `TFL_SPIN_MS_0;
      3'h1: spin_ms = `TFL_SPIN_MS_1;
      3'h2: spin_ms = `TFL_SPIN_MS_2;
      3'h3: spin_ms = `TFL_SPIN_MS_3;
      3'h4: spin_ms = `TFL_SPIN_MS_4;
      3'h5: spin_ms = `TFL_SPIN_MS_5;
      3'h6: spin_ms = `TFL_SPIN_MS_6;
      default: spin_ms = `TFL_SPIN_MS_7;
    endcase
  end

  // (RULE_15) mode from cfg1; filtered runs the plain loop here,
  // speed feedback falls back to the direct duty field
  always @* begin
    if (auto_on && !cfg1_reg[`TFL_B_FILT])
      fan_mode = `TFL_MODE_AUTO;
    else if (auto_on)
      fan_mode = `TFL_MODE_FILT;
    else if (cfg1_reg[`TFL_B_RPM])
      fan_mode = `TFL_MODE_RPM;
    else
      fan_mode = `TFL_MODE_DIRECT;
  end

  reg loop_prev_reg;
  always @(posedge sys_clk) begin
    if (reset) begin
      loop_prev_reg <= 1'b0;
      spin_reg <= 1'b0;
      spin_cnt_reg <= 32'h0000_0000;
      alarm_prev_reg <= 1'b0;
      pwm_duty <= 4'h0;
    end else begin
      loop_prev_reg <= loop_on & auto_on;
      alarm_prev_reg <= force_full;
      // (RULE_16) spin-up at full duty on switch-on
      if (auto_on & loop_on & ~loop_prev_reg) begin
        spin_reg <= 1'b1;
        spin_cnt_reg <= spin_ms * MS_CYCLES;
      end else if (spin_reg) begin
        if (spin_cnt_reg <= 32'h0000_0001 || !loop_on)
          spin_reg <= 1'b0;
        spin_cnt_reg <= spin_cnt_reg - 32'h0000_0001;
      end
      if (force_full | spin_reg | (auto_on & loop_on & ~loop_prev_reg))
        pwm_duty <= `TFL_DUTY_FULL;
      // (RULE_21) loop duty starts at the minimum field
      else if (auto_on)
        pwm_duty <= loop_on ? loop_duty : 4'h0;
      else
        pwm_duty <= fanspd_reg[3:0];
    end
  end

  // ------------------------------------------------------------
  // register writes and reads
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (reset) begin
      cfg1_reg <= `TFL_R_CFG1;
      cfg2_reg <= `TFL_R_CFG2;
      fanchr_reg <= `TFL_R_FANCHR;
      fanspd_reg <= `TFL_R_FANSPD;
      otbeh_reg <= `TFL_R_OTBEH;
      loc_hi_reg <= `TFL_R_HI;
      loc_lo_reg <= `TFL_R_LO;
      loc_ot_reg <= `TFL_R_OT;
      rem_hi_reg <= `TFL_R_HI;
      rem_lo_reg <= `TFL_R_LO;
      rem_ot_reg <= `TFL_R_OT;
      loc_loop_reg <= `TFL_R_LOOP;
      rem_loop_reg <= `TFL_R_LOOP;
      stat1_reg <= 8'h00;
      stat2_reg <= 8'h00;
      reg_rdata <= 8'h00;
    end else begin
      stat1_reg <= stat1_next;
      stat2_reg <= stat2_next;
      if (reg_wr) begin
        if (reg_addr == `TFL_A_CFG1)
          cfg1_reg <= reg_wdata;
        else if (reg_addr == `TFL_A_CFG2)
          cfg2_reg <= reg_wdata;
        else if (reg_addr == `TFL_A_FANCHR)
          fanchr_reg <= reg_wdata;
        else if (reg_addr == `TFL_A_FANSPD)
          fanspd_reg <= {4'h0, reg_wdata[3:0]};
        else if (reg_addr == `TFL_A_OTBEH)
          otbeh_reg <= {reg_wdata[`TFL_B_OT2FAN], 7'h00};
        else if (reg_addr == `TFL_A_LOC_HI)
          loc_hi_reg <= reg_wdata;
        else if (reg_addr == `TFL_A_LOC_LO)
          loc_lo_reg <= reg_wdata;
        else if (reg_addr == `TFL_A_LOC_OT)
          loc_ot_reg <= reg_wdata;
        else if (reg_addr == `TFL_A_REM_HI)
          rem_hi_reg <= reg_wdata;
        else if (reg_addr == `TFL_A_REM_LO)
          rem_lo_reg <= reg_wdata;
        else if (reg_addr == `TFL_A_REM_OT)
          rem_ot_reg <= reg_wdata;
        else if (reg_addr == `TFL_A_LOC_LOOP)
          loc_loop_reg <= reg_wdata;
        else if (reg_addr == `TFL_A_REM_LOOP)
          rem_loop_reg <= reg_wdata;
      end
      if (reg_rd) begin
        if (reg_addr == `TFL_A_CFG1)
          reg_rdata <= cfg1_reg;
        else if (reg_addr == `TFL_A_CFG2)
          reg_rdata <= cfg2_reg;
        else if (reg_addr == `TFL_A_STAT1)
          reg_rdata <= stat1_reg;
        else if (reg_addr == `TFL_A_STAT2)
          reg_rdata <= stat2_reg;
        else if (reg_addr == `TFL_A_FANCHR)
          reg_rdata <= fanchr_reg;
        else if (reg_addr == `TFL_A_FANSPD)
          reg_rdata <= fanspd_reg;
        else if (reg_addr == `TFL_A_OTBEH)
          // revision field value is arbitrary
          reg_rdata <= {otbeh_reg[`TFL_B_OT2FAN], `TFL_REVISION};
        else if (reg_addr == `TFL_A_LOC_HI)
          reg_rdata <= loc_hi_reg;
        else if (reg_addr == `TFL_A_LOC_LO)
          reg_rdata <= loc_lo_reg;
        else if (reg_addr == `TFL_A_LOC_OT)
          reg_rdata <= loc_ot_reg;
        else if (reg_addr == `TFL_A_REM_HI)
          reg_rdata <= rem_hi_reg;
        else if (reg_addr == `TFL_A_REM_LO)
          reg_rdata <= rem_lo_reg;
        else if (reg_addr == `TFL_A_REM_OT)
          reg_rdata <= rem_ot_reg;
        else if (reg_addr == `TFL_A_LOC_LOOP)
          reg_rdata <= loc_loop_reg;
        else if (reg_addr == `TFL_A_REM_LOOP)
          reg_rdata <= rem_loop_reg;
        else
          reg_rdata <= 8'h00;
      end
    end
  end

endmodule // tfl_top

/* File: verification/tb_top.sv */
// Purpose: register-level tests of tfl_top
// Assumes: inputs change at the falling edge
// Notes: MS_CYCLES of 1 keeps spin-up short
`timescale 1ns/1ns
`include "tfl_defines.vh"
module tb_top;
  reg sys_clk = 1'b0;
  reg reset = 1'b1;
  reg [7:0] reg_addr = 8'h00;
  reg reg_wr = 1'b0;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_rd = 1'b0;
  reg ara_ack = 1'b0;
  reg conv_done = 1'b0;
  reg [7:0] loc_t = 8'h19;
  reg [7:0] rem_t = 8'h19;
  reg tach_fail = 1'b0;
  reg diode_err = 1'b1;
  reg pull_low = 1'b0;
  wire [7:0] reg_rdata;
  wire pin_o, pin_oe_n, pin_lvl, alert_n;
  wire [3:0] pwm_duty;
  wire [1:0] fan_mode, bus_addr_low;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  int i;
  reg [7:0] mt [4] = '{8'h80, 8'h90, 8'h00, 8'h08};
  always #4 sys_clk = ~sys_clk;
  tfl_top #(.MS_CYCLES(1)) tfl_top_inst (.sys_clk(sys_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ara_ack(ara_ack),
    .conv_done(conv_done), .local_temp(loc_t), .remote_temp(rem_t),
    .tach_fail(tach_fail), .diode_err(diode_err), .addr_pin_high(1'b1),
    .addr_pin_low(1'b0), .overtemp_pin_n_i(pin_lvl),
    .overtemp_pin_n_o(pin_o), .overtemp_pin_n_oe_n(pin_oe_n),
    .alert_n(alert_n), .pwm_duty(pwm_duty), .fan_mode(fan_mode),
    .bus_addr_low(bus_addr_low));
  tfl_pin_host tfl_pin_host_inst (.pull_low(pull_low), .dev_o(pin_o),
    .dev_oe_n(pin_oe_n), .pin_level(pin_lvl));
  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task ck(input [7:0] g, input [7:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  task rc(input [7:0] a, input [7:0] e);
    @(negedge sys_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    ck(reg_rdata, e);
  endtask
  task cv(input [7:0] l, input [7:0] r);
    @(negedge sys_clk);
    conv_done = 1'b1;
    loc_t = l;
    rem_t = r;
    @(negedge sys_clk);
    conv_done = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask
  task pulse_ara;
    @(negedge sys_clk);
    ara_ack = 1'b1;
    @(negedge sys_clk);
    ara_ack = 1'b0;
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_mismatch++;
      wrap_up;
    end
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    repeat (2) @(negedge sys_clk);
    diode_err = 1'b0;
    rc(`TFL_A_CFG2, `TFL_R_CFG2);
    rc(`TFL_A_OTBEH, 8'h81);
    rc(8'h7f, 8'h00);
    ck({6'h0, bus_addr_low}, 8'h02);
    rc(`TFL_A_STAT1, 8'h20);
    rc(`TFL_A_STAT1, 8'h20);
    $display("defaults done");
    cv(8'h50, 8'hf6);
    ck({7'h0, alert_n}, 8'h00);
    pulse_ara();
    ck({7'h0, alert_n}, 8'h01);
    cv(8'h50, 8'hf6);
    ck({7'h0, alert_n}, 8'h00);
    rc(`TFL_A_STAT1, 8'h68);
    rc(`TFL_A_STAT1, 8'h20);
    cv(8'h50, 8'h19);
    rc(`TFL_A_STAT1, 8'h60);
    cv(8'h50, 8'h19);
    wr(`TFL_A_CFG2, 8'h02);
    ck({7'h0, alert_n}, 8'h01);
    cv(8'h50, 8'h19);
    rc(`TFL_A_STAT1, 8'h20);
    wr(`TFL_A_CFG2, 8'h03);
    $display("limit tests done");
    wr(`TFL_A_LOC_HI, 8'h7f);
    cv(8'h5a, 8'h19);
    ck({6'h0, pin_oe_n, pin_o}, 8'h00);
    ck({4'h0, pwm_duty}, 8'h0f);
    rc(`TFL_A_STAT2, 8'h40);
    rc(`TFL_A_STAT1, 8'h21);
    ck({7'h0, alert_n}, 8'h01);
    cv(8'h52, 8'h19);
    ck({7'h0, pin_oe_n}, 8'h00);
    ck({7'h0, alert_n}, 8'h01);
    rc(`TFL_A_STAT2, 8'h00);
    rc(`TFL_A_STAT1, 8'h20);
    cv(8'h4f, 8'h19);
    ck({7'h0, pin_oe_n}, 8'h01);
    wr(`TFL_A_OTBEH, 8'h00);
    cv(8'h5a, 8'h19);
    ck({4'h0, pwm_duty}, 8'h00);
    ck({7'h0, alert_n}, 8'h00);
    rc(`TFL_A_STAT2, 8'h40);
    cv(8'h46, 8'h19);
    $display("overtemp tests done");
    pull_low = 1'b1;
    repeat (8) @(negedge sys_clk);
    ck({4'h0, pwm_duty}, 8'h0f);
    rc(`TFL_A_STAT2, 8'h80);
    rc(`TFL_A_STAT1, 8'h21);
    rc(`TFL_A_STAT1, 8'h20);
    pull_low = 1'b0;
    repeat (8) @(negedge sys_clk);
    for (i = 0; i < 2; i++) begin
      @(negedge sys_clk);
      tach_fail = 1'b1;
      @(negedge sys_clk);
      tach_fail = 1'b0;
      repeat (2) @(negedge sys_clk);
      rc(`TFL_A_STAT1, 8'h22);
      rc(`TFL_A_STAT1, 8'h20);
    end
    $display("pin and tach tests done");
    wr(`TFL_A_FANCHR, 8'h00);
    cv(8'h19, 8'h28);
    ck({4'h0, pwm_duty}, 8'h00);
    cv(8'h19, 8'h32);
    ck({4'h0, pwm_duty}, 8'h0f);
    repeat (210) @(negedge sys_clk);
    cv(8'h19, 8'h32);
    ck({4'h0, pwm_duty}, 8'h0a);
    cv(8'h19, 8'h3c);
    ck({4'h0, pwm_duty}, 8'h0f);
    cv(8'h19, 8'h24);
    ck({7'h0, pwm_duty == 4'h0}, 8'h00);
    cv(8'h19, 8'h22);
    ck({4'h0, pwm_duty}, 8'h00);
    wr(`TFL_A_FANSPD, 8'h08);
    wr(`TFL_A_REM_LOOP, 8'h62);
    cv(8'h19, 8'h32);
    repeat (210) @(negedge sys_clk);
    cv(8'h19, 8'h32);
    ck({4'h0, pwm_duty}, 8'h09);
    $display("fan loop tests done");
    for (i = 0; i < 4; i++) begin
      wr(`TFL_A_CFG1, mt[i]);
      ck({6'h0, fan_mode}, i[7:0]);
    end
    wr(`TFL_A_FANSPD, 8'h09);
    cv(8'h19, 8'h19);
    ck({4'h0, pwm_duty}, 8'h09);
    $display("mode tests done");
    wrap_up();
  end
endmodule // tb_top

/* File: verification/tfl_monitor.sv */
// Purpose: port checker for tfl_top
// Assumes: one clock domain, synchronous reset
// Notes: bound to every tfl_top instance
`timescale 1ns/1ns
module tfl_monitor (
  // clock and reset
  input wire sys_clk,
  input wire reset,
  // observed ports
  input wire reg_rd,
  input wire reg_wr,
  input wire ara_ack,
  input wire conv_done,
  input wire overtemp_pin_n_i,
  input wire overtemp_pin_n_oe_n,
  input wire alert_n,
  input wire [3:0] pwm_duty,
  input wire [1:0] fan_mode,
  input wire [1:0] bus_addr_low
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  AST_ADDR_FIXED: assert property (
    !$past(reset, 4) |=> $stable(bus_addr_low)) else $error("strap moved");
  AST_ALERT_CAUSE: assert property (
    $fell(alert_n) |-> $past(conv_done, 2)) else $error("alert no cause");
  AST_OT_SET: assert property (
    $fell(overtemp_pin_n_oe_n) |-> $past(conv_done))
    else $error("pin pulled off cycle");
  AST_OT_HOLD: assert property (
    $rose(overtemp_pin_n_oe_n) |-> $past(conv_done))
    else $error("pin freed off cycle");
  AST_ALERT_REL: assert property (
    $rose(alert_n) |-> $past(reg_rd || reg_wr || ara_ack))
    else $error("alert freed alone");
  AST_ARA_REL: assert property (
    ara_ack && !conv_done && !$past(conv_done) |=> alert_n)
    else $error("alert held after response");
  AST_EXT_FULL: assert property (
    (!overtemp_pin_n_i && overtemp_pin_n_oe_n) [*6] |-> pwm_duty == 4'hf)
    else $error("outside pull not full");
  AST_SPIN_FULL: assert property (
    fan_mode == 2'h0 && $past(pwm_duty) == 4'h0 && pwm_duty != 4'h0
    |-> pwm_duty == 4'hf) else $error("start without spin");
endmodule // tfl_monitor
bind tfl_top tfl_monitor tfl_monitor_inst (.sys_clk(sys_clk), .reset(reset),
  .reg_rd(reg_rd), .reg_wr(reg_wr), .ara_ack(ara_ack),
  .conv_done(conv_done), .overtemp_pin_n_i(overtemp_pin_n_i),
  .overtemp_pin_n_oe_n(overtemp_pin_n_oe_n), .alert_n(alert_n),
  .pwm_duty(pwm_duty), .fan_mode(fan_mode), .bus_addr_low(bus_addr_low));

/* File: verification/tfl_pin_host.sv */
// Purpose: outside party on the open-drain overtemp pin
// Assumes: the pin carries a pull-up
// Notes: the device pull and the outside pull are wire-anded
`timescale 1ns/1ns
module tfl_pin_host (
  // control from the bench
  input wire pull_low,
  // device side
  input wire dev_o,
  input wire dev_oe_n,
  // resolved pin
  output wire pin_level
);
  // pull-up wins only when nobody sinks the line
  assign pin_level = !pull_low && (dev_oe_n || dev_o);
endmodule // tfl_pin_host
